/* File: hw/lcb_gap.sv */
// package of the line clock and bus mastership block, plus the mastership-gap counter
`timescale 1ns/1ps
package lcb_pkg;
  // ==========================================================
  // timing
  localparam int unsigned LCB_CLK_NS = 8;
  localparam int unsigned LCB_CLK_HZ = 125_000_000;
  localparam int unsigned LCB_GAP_UNIT_NS = 400;
  localparam int unsigned LCB_GAP_UNIT_CYC = LCB_GAP_UNIT_NS / LCB_CLK_NS;
  localparam int unsigned LCB_HZ_50 = 50;
  localparam int unsigned LCB_HZ_60 = 60;
  localparam int unsigned LCB_HZ_800 = 800;
  localparam int unsigned LCB_DIV_50 = LCB_CLK_HZ / LCB_HZ_50;
  localparam int unsigned LCB_DIV_60 = LCB_CLK_HZ / LCB_HZ_60;
  localparam int unsigned LCB_DIV_800 = LCB_CLK_HZ / LCB_HZ_800;
  // ==========================================================
  // apb register offsets
  localparam logic [7:0] LCB_OFF_BCR = 8'h00;
  localparam logic [7:0] LCB_OFF_CLK = 8'h04;
  localparam logic [7:0] LCB_OFF_IST = 8'h08;
  localparam logic [7:0] LCB_OFF_IMSK = 8'h0C;
  // ==========================================================
  // board_control_register and clock register fields
  localparam int LCB_BCR_GAP_LSB = 0;
  localparam int LCB_BCR_ROM_LSB = 4;
  localparam int LCB_BCR_HALT = 8;
  localparam int LCB_BCR_SEL_LSB = 10;
  localparam int LCB_BCR_CSR_DIS = 12;
  localparam int LCB_BCR_FORCE = 13;
  localparam int LCB_BCR_RESTART = 15;
  localparam int LCB_CLK_IE = 6;
  localparam int LCB_CLK_FLAG = 7;
  // ==========================================================
  // io page decode (22-bit byte addresses)
  localparam logic [21:0] LCB_IO_CLK_CSR = 22'h3FFF66;
  localparam logic [12:0] LCB_PAGE_173 = 13'h1FFB;
  localparam logic [12:0] LCB_PAGE_165 = 13'h1FF5;
  localparam logic [2:0] LCB_PRIO_MAX = 3'h5;
  // ==========================================================
  // interrupt status bits and clock sources
  localparam int LCB_EV_TICK = 0;
  localparam int LCB_EV_GAP = 1;
  localparam int LCB_EV_HALT = 2;
  localparam logic [1:0] LCB_SEL_EXT = 2'h0;
  localparam logic [1:0] LCB_SEL_50 = 2'h1;
  localparam logic [1:0] LCB_SEL_60 = 2'h2;
  localparam logic [1:0] LCB_SEL_800 = 2'h3;
endpackage

module lcb_gap_counter import lcb_pkg::*; #(
  parameter int unsigned GAP_UNIT_CYC = LCB_GAP_UNIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] mastership_gap_count,
  input wire logic dma_arb,
  output logic dma_suppress,
  output logic gap_overflow
);
  typedef enum logic [2:0] {
    LCB_G_OFF = 3'h1,
    LCB_G_RUN = 3'h2,
    LCB_G_HOLD = 3'h4
  } lcb_gap_e;

  typedef struct packed {
    lcb_gap_e st;
    logic [12:0] cnt;
    logic ov;
  } lcb_gap_s;

  lcb_gap_s q;
  lcb_gap_s next_q;

  // limit is zero at setting 0 and doubles with each step from setting 1 upward
  function automatic logic [12:0] gap_limit(input logic [2:0] s);
    logic [12:0] u;
    u = 13'(GAP_UNIT_CYC);
    gap_limit = (s == 3'h0) ? 13'h0 : 13'(u << (s - 3'h1));
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    next_q = q;
    next_q.ov = 1'b0;
    case (q.st)
      LCB_G_OFF: begin
        next_q.cnt = 13'h0;
        if (mastership_gap_count != 3'h0) begin
          next_q.st = LCB_G_RUN;
        end
      end
      LCB_G_RUN: begin
        if (mastership_gap_count == 3'h0) begin
          next_q.st = LCB_G_OFF;
          next_q.cnt = 13'h0;
        end else if (q.cnt + 13'h1 >= gap_limit(mastership_gap_count)) begin
          next_q.st = LCB_G_HOLD;
          next_q.cnt = 13'h0;
          next_q.ov = 1'b1;
        end else begin
          next_q.cnt = q.cnt + 13'h1;
        end
      end
      LCB_G_HOLD: begin
        if (dma_arb || mastership_gap_count == 3'h0) begin
          next_q.st = LCB_G_OFF;
        end
      end
      default: begin
        next_q.st = LCB_G_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: LCB_G_OFF, cnt: 13'h0, ov: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign dma_suppress = (q.st == LCB_G_HOLD);
  assign gap_overflow = q.ov;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_gap_off;
    mastership_gap_count == 3'h0 |=> ##1 !dma_suppress;
  endproperty
  a_gap_off: assert property (p_gap_off) else $error("gap counter active at setting 0");

  sequence s_hold_wait;
    dma_suppress && !dma_arb && mastership_gap_count != 3'h0;
  endsequence
  property p_gap_hold;
    s_hold_wait |=> dma_suppress;
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("suppress dropped before arbitration");

  property p_gap_time;
    $rose(dma_suppress) |-> $past(q.cnt) + 13'h1 == gap_limit($past(mastership_gap_count));
  endproperty
  a_gap_time: assert property (p_gap_time) else $error("overflow at wrong count");

  sequence s_released;
    dma_suppress ##1 !dma_suppress;
  endsequence
  property p_gap_restart;
    s_released |-> q.cnt == 13'h0;
  endproperty
  a_gap_restart: assert property (p_gap_restart) else $error("gap count not restarted");
endmodule // lcb_gap_counter

/* File: hw/lcb_ctrl.sv */
// line clock, boot page decode, halt-on-break and mastership gap control
// Functional notes
// - three-bit gap setting 0..7; zero turns the gap counter off
// - on overflow dma requests are suppressed so the processor wins next arbitration
// - overflow time 0.4 us at setting 1, doubling each step to 25.6 us
// - control bit 12 disables clock status register, else it answers at 17777546
// - control bit 13 forces clock interrupts when processor priority is 5 or less
// - without force, clock needs status enabled, its bit 6 set, priority 5 or less
// - control bits 11:10 pick clock: external event, 50, 60 or 800 Hz
// - two 256-word boot pages decoded at 17773000 and 17765000
// - both boot pages re-enabled at every power-up and restart
// - page disable code: 0 none, 1 page 17765, 2 page 17773, 3 both
// - halt-on-break halts on console break when enabled, else breaks are ignored
// - halt-on-break armed only after first break or valid character
// - a status bit tells power-up from restart
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module lcb_ctrl import lcb_pkg::*; #(
  parameter int unsigned GAP_UNIT_CYC = LCB_GAP_UNIT_CYC,
  parameter int unsigned DIV_50 = LCB_DIV_50,
  parameter int unsigned DIV_60 = LCB_DIV_60,
  parameter int unsigned DIV_800 = LCB_DIV_800
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic sys_restart,
  input wire logic [21:0] io_addr,
  output logic clk_csr_sel,
  output logic rom_page_173_sel,
  output logic rom_page_165_sel,
  input wire logic dma_arb,
  output logic dma_suppress,
  input wire logic external_event_input,
  input wire logic [2:0] cpu_priority,
  input wire logic clk_irq_ack,
  output logic clk_irq_req,
  input wire logic break_detect,
  input wire logic rx_char_valid,
  output logic halt_req
);
  typedef struct packed {
    logic [2:0] gap;
    logic [1:0] rom_dis;
    logic halt_en;
    logic [1:0] clksel;
    logic csr_dis;
    logic force_irq;
    logic restarted;
    logic clk_ie;
    logic clk_flag;
    logic [2:0] ist;
    logic [2:0] imask;
    logic armed;
    logic halt;
    logic ext_q;
    logic [21:0] div;
    logic tick;
    logic [31:0] rdata;
  } lcb_state_s;

  lcb_state_s q;
  lcb_state_s next_q;
  logic gap_ov;

  // 512-byte page match on the io address
  function automatic logic page_hit(input logic [21:0] a, input logic [12:0] pg);
    page_hit = (a[21:9] == pg);
  endfunction

  function automatic logic [21:0] div_limit(input logic [1:0] sel);
    case (sel)
      LCB_SEL_50: div_limit = 22'(DIV_50 - 1);
      LCB_SEL_60: div_limit = 22'(DIV_60 - 1);
      default: div_limit = 22'(DIV_800 - 1);
    endcase
  endfunction

  // ==========================================================
  // apb decode
  logic setup_ph;
  logic wr_acc;
  logic bad_addr;
  assign setup_ph = psel && !penable;
  // disabled clock register answers as unmapped
  assign bad_addr = !(paddr == LCB_OFF_BCR || paddr == LCB_OFF_IST || paddr == LCB_OFF_IMSK
                     || (paddr == LCB_OFF_CLK && !q.csr_dis));
  assign wr_acc = psel && penable && pwrite && !bad_addr;
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad_addr;

  logic [31:0] bcr_rd;
  logic [31:0] clk_rd;
  always_comb begin
    bcr_rd = 32'h0;
    bcr_rd[LCB_BCR_GAP_LSB +: 3] = q.gap;
    bcr_rd[LCB_BCR_ROM_LSB +: 2] = q.rom_dis;
    bcr_rd[LCB_BCR_HALT] = q.halt_en;
    bcr_rd[LCB_BCR_SEL_LSB +: 2] = q.clksel;
    bcr_rd[LCB_BCR_CSR_DIS] = q.csr_dis;
    bcr_rd[LCB_BCR_FORCE] = q.force_irq;
    bcr_rd[LCB_BCR_RESTART] = q.restarted;
    clk_rd = 32'h0;
    clk_rd[LCB_CLK_IE] = q.clk_ie;
    clk_rd[LCB_CLK_FLAG] = q.clk_flag;
  end

  // ==========================================================
  // next state
  logic src_tick;
  logic [2:0] ev;
  logic prio_ok;
  assign prio_ok = (cpu_priority <= LCB_PRIO_MAX);

  always_comb begin
    next_q = q;
    next_q.ext_q = external_event_input;
    next_q.halt = 1'b0;
    src_tick = (q.clksel == LCB_SEL_EXT) ? (external_event_input && !q.ext_q) : q.tick;
    next_q.tick = 1'b0;
    if (q.clksel == LCB_SEL_EXT || q.div >= div_limit(q.clksel)) begin
      next_q.div = 22'h0;
      next_q.tick = (q.clksel != LCB_SEL_EXT);
    end else begin
      next_q.div = q.div + 22'h1;
    end
    // register writes
    if (wr_acc && paddr == LCB_OFF_BCR) begin
      next_q.gap = pwdata[LCB_BCR_GAP_LSB +: 3];
      next_q.rom_dis = pwdata[LCB_BCR_ROM_LSB +: 2];
      next_q.halt_en = pwdata[LCB_BCR_HALT];
      next_q.clksel = pwdata[LCB_BCR_SEL_LSB +: 2];
      next_q.csr_dis = pwdata[LCB_BCR_CSR_DIS];
      next_q.force_irq = pwdata[LCB_BCR_FORCE];
    end
    if (wr_acc && paddr == LCB_OFF_CLK) begin
      next_q.clk_ie = pwdata[LCB_CLK_IE];
      next_q.clk_flag = pwdata[LCB_CLK_FLAG];
    end
    if (wr_acc && paddr == LCB_OFF_IMSK) begin
      next_q.imask = pwdata[2:0];
    end
    if (clk_irq_ack) begin
      next_q.clk_flag = 1'b0;
    end
    if (src_tick) begin
      next_q.clk_flag = 1'b1;
    end
    // halt on break only when enabled
    // first break or character only arms
    if (break_detect && q.armed && q.halt_en) begin
      next_q.halt = 1'b1;
    end
    if (break_detect || rx_char_valid) begin
      next_q.armed = 1'b1;
    end
    // sticky events, set wins over write-one clear
    ev = 3'h0;
    ev[LCB_EV_TICK] = src_tick;
    ev[LCB_EV_GAP] = gap_ov;
    ev[LCB_EV_HALT] = next_q.halt;
    if (wr_acc && paddr == LCB_OFF_IST) begin
      next_q.ist = q.ist & ~pwdata[2:0];
    end
    next_q.ist = next_q.ist | ev;
    if (sys_restart) begin
      next_q.rom_dis = 2'h0;
      next_q.armed = 1'b0;
      next_q.restarted = 1'b1;
    end
    if (setup_ph) begin
      case (paddr)
        LCB_OFF_BCR: next_q.rdata = bcr_rd;
        LCB_OFF_CLK: next_q.rdata = q.csr_dis ? 32'h0 : clk_rd;
        LCB_OFF_IST: next_q.rdata = {29'h0, q.ist};
        LCB_OFF_IMSK: next_q.rdata = {29'h0, q.imask};
        default: next_q.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = q.rdata;
  assign irq = |(q.ist & q.imask);
  assign halt_req = q.halt;
  assign clk_irq_req = q.clk_flag && prio_ok && (q.force_irq || (!q.csr_dis && q.clk_ie));
  assign clk_csr_sel = !q.csr_dis && io_addr == LCB_IO_CLK_CSR;
  assign rom_page_165_sel = page_hit(io_addr, LCB_PAGE_165) && !q.rom_dis[0];
  assign rom_page_173_sel = page_hit(io_addr, LCB_PAGE_173) && !q.rom_dis[1];

  lcb_gap_counter #(
    .GAP_UNIT_CYC(GAP_UNIT_CYC)
  ) u_gap (
    .pclk(pclk),
    .presetn(presetn),
    .mastership_gap_count(q.gap),
    .dma_arb(dma_arb),
    .dma_suppress(dma_suppress),
    .gap_overflow(gap_ov)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_csr_off;
    q.csr_dis |-> !clk_csr_sel;
  endproperty
  a_csr_off: assert property (p_csr_off) else $error("clock register decoded while disabled");

  property p_force;
    q.force_irq && q.clk_flag && cpu_priority <= LCB_PRIO_MAX |-> clk_irq_req;
  endproperty
  a_force: assert property (p_force) else $error("forced clock interrupt missing");

  property p_gate;
    !q.force_irq && (!q.clk_ie || q.csr_dis || cpu_priority > LCB_PRIO_MAX) |-> !clk_irq_req;
  endproperty
  a_gate: assert property (p_gate) else $error("clock interrupt not gated");

  sequence s_ext_edge;
    q.clksel == LCB_SEL_EXT && external_event_input && !q.ext_q && !clk_irq_ack;
  endsequence
  property p_ext;
    s_ext_edge |=> q.clk_flag && q.ist[LCB_EV_TICK];
  endproperty
  a_ext: assert property (p_ext) else $error("external event tick lost");

  property p_rom;
    q.rom_dis == 2'h3 |-> !rom_page_165_sel && !rom_page_173_sel;
  endproperty
  a_rom: assert property (p_rom) else $error("disabled boot page decoded");

  property p_page;
    q.rom_dis == 2'h0 && io_addr[21:9] == LCB_PAGE_173 |-> rom_page_173_sel;
  endproperty
  a_page: assert property (p_page) else $error("boot page not decoded");

  property p_restart;
    sys_restart |=> q.rom_dis == 2'h0 && q.restarted && !q.armed;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not reset state");

  property p_halt_arm;
    !q.armed ##1 !q.armed |-> !halt_req;
  endproperty
  a_halt_arm: assert property (p_halt_arm) else $error("halt before first character");

  property p_halt_en;
    halt_req |-> $past(q.halt_en) && $past(break_detect);
  endproperty
  a_halt_en: assert property (p_halt_en) else $error("halt without enable and break");
endmodule // lcb_ctrl

/* File: sim/lcb_dma_model.sv */
// backplane arbiter model that grants the processor once dma is held off
`timescale 1ns/1ps
module lcb_dma_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dma_suppress,
  input wire logic [3:0] grant_delay,
  output logic dma_arb
);
  // ==========================================================
  // arbitration
  logic [3:0] wait_cnt;
  // grant_delay lets a slow bus keep suppression standing for a while
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      dma_arb <= 1'b0;
    end else begin
      dma_arb <= 1'b0;
      if (dma_suppress && !dma_arb) begin
        if (wait_cnt >= grant_delay) begin
          dma_arb <= 1'b1;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule // lcb_dma_model

/* File: sim/lcb_ctrl_tb_top.sv */
// self-checking testbench of the line clock and bus mastership block
`timescale 1ns/1ps
module lcb_ctrl_tb_top import lcb_pkg::*; ();
  // ==========================================================
  // signals
  localparam int GAP = 4;
  localparam int DV [4] = '{0, 20, 24, 8};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, clk_csr_sel, rom_page_173_sel, rom_page_165_sel;
  logic sys_restart = 0, ext_ev = 0, clk_irq_ack = 0, break_detect = 0, rx_char_valid = 0;
  logic [21:0] io_addr = 22'h0;
  logic [2:0] cpu_priority = 3'h5;
  logic [3:0] grant_delay = 4'h1;
  logic dma_arb, dma_suppress, clk_irq_req, halt_req, h;
  logic [33:0] exp_q[$];
  logic [33:0] exp_e;
  logic [7:0] rnd = 8'h49;
  int num_errors = 0, n_compared = 0, n;
  longint t0;
  always #4 pclk = ~pclk;
  lcb_ctrl #(.GAP_UNIT_CYC(GAP), .DIV_50(20), .DIV_60(24), .DIV_800(8)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sys_restart(sys_restart), .io_addr(io_addr), .clk_csr_sel(clk_csr_sel),
    .rom_page_173_sel(rom_page_173_sel), .rom_page_165_sel(rom_page_165_sel),
    .dma_arb(dma_arb), .dma_suppress(dma_suppress), .external_event_input(ext_ev),
    .cpu_priority(cpu_priority), .clk_irq_ack(clk_irq_ack), .clk_irq_req(clk_irq_req),
    .break_detect(break_detect), .rx_char_valid(rx_char_valid), .halt_req(halt_req));
  lcb_dma_model bus (.pclk(pclk), .presetn(presetn), .dma_suppress(dma_suppress),
    .grant_delay(grant_delay), .dma_arb(dma_arb));
  // ==========================================================
  // checking and ending
  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    give_verdict();
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  // each access takes the oldest note: error flag always, data on reads
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready) begin
      exp_e = exp_q.pop_front();
      cmp_bit(pslverr, exp_e[32]);
      if (!exp_e[33]) begin
        cmp_rd(prdata, exp_e[31:0]);
      end
    end
  end
  // ==========================================================
  // drivers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic err);
    int k;
    k = 0;
    exp_q.push_back({w, err, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50) timeout();
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0, e, err);
  endtask
  function automatic logic [31:0] bcr(input logic [2:0] g, input logic [1:0] rom,
    input logic hlt, input logic [1:0] s, input logic dis, input logic frc);
    return {18'h0, frc, dis, s, 1'b0, hlt, 2'b0, rom, 1'b0, g};
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return clk_irq_req;
      1: return dma_suppress;
      2: return halt_req;
      default: return irq;
    endcase
  endfunction
  // bounded wait for a level, adding the cycles spent to n
  task automatic wait_lvl(input int w, input logic v, input int lim, inout int n);
    int k;
    k = 0;
    while (sig(w) !== v && k < lim) begin
      @(posedge pclk);
      #1;
      k++;
    end
    n = n + k;
    if (k >= lim) timeout();
  endtask
  task automatic seen(input int w, input int cyc, output logic hit);
    hit = sig(w);
    repeat (cyc) begin
      @(posedge pclk);
      #1;
      hit = hit | sig(w);
    end
  endtask
  task automatic pulse(input int w);
    @(posedge pclk);
    case (w)
      0: sys_restart <= 1'b1;
      1: clk_irq_ack <= 1'b1;
      2: break_detect <= 1'b1;
      3: rx_char_valid <= 1'b1;
      default: ext_ev <= 1'b1;
    endcase
    @(posedge pclk);
    sys_restart <= 1'b0;
    clk_irq_ack <= 1'b0;
    break_detect <= 1'b0;
    rx_char_valid <= 1'b0;
    ext_ev <= 1'b0;
    #1;
  endtask
  task automatic dec(input logic [21:0] a, input logic e3, input logic e5, input logic ec);
    @(posedge pclk);
    io_addr <= a;
    #1;
    cmp_bit(rom_page_173_sel, e3);
    cmp_bit(rom_page_165_sel, e5);
    cmp_bit(clk_csr_sel, ec);
  endtask
  task automatic prio(input logic [2:0] p, input logic e);
    @(posedge pclk);
    cpu_priority <= p;
    #1;
    cmp_bit(clk_irq_req, e);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(LCB_OFF_BCR, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(LCB_OFF_BCR, bcr(0, c[1:0], 0, 0, 0, 0));
      dec(22'h3FF600, !c[1], 1'b0, 1'b0);
      dec(22'h3FEBFE, 1'b0, !c[0], 1'b0);
      dec(22'h3FF800, 1'b0, 1'b0, 1'b0);
    end
    pulse(0);
    dec(22'h3FF7FE, 1'b1, 1'b0, 1'b0);
    dec(22'h3FEA00, 1'b0, 1'b1, 1'b0);
    rd(LCB_OFF_BCR, 32'h8000, 1'b0);
    wr(LCB_OFF_BCR, bcr(0, 0, 0, 0, 1, 0));
    dec(22'h3FFF66, 1'b0, 1'b0, 1'b0);
    rd(LCB_OFF_CLK, 32'h0, 1'b1);
    wr(LCB_OFF_BCR, bcr(0, 0, 0, 0, 0, 0));
    dec(22'h3FFF66, 1'b0, 1'b0, 1'b1);
    wr(LCB_OFF_CLK, 32'h40);
    wr(LCB_OFF_IST, 32'h7);
    wr(LCB_OFF_IMSK, 32'h1);
    pulse(4);
    wait_lvl(3, 1'b1, 4, n);
    cmp_bit(clk_irq_req, 1'b1);
    rd(LCB_OFF_IST, 32'h1, 1'b0);
    wr(LCB_OFF_IMSK, 32'h0);
    wait_lvl(3, 1'b0, 3, n);
    wr(LCB_OFF_IMSK, 32'h1);
    wait_lvl(3, 1'b1, 3, n);
    wr(LCB_OFF_IST, 32'h1);
    wait_lvl(3, 1'b0, 3, n);
    repeat (6) begin
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      prio(rnd[2:0], rnd[2:0] <= 3'h5);
    end
    prio(3'h5, 1'b1);
    wr(LCB_OFF_CLK, 32'h80);
    cmp_bit(clk_irq_req, 1'b0);
    wr(LCB_OFF_CLK, 32'hC0);
    wr(LCB_OFF_BCR, bcr(0, 0, 0, 0, 1, 0));
    cmp_bit(clk_irq_req, 1'b0);
    // software keeps the clock register disabled while forcing ticks
    wr(LCB_OFF_BCR, bcr(0, 0, 0, 0, 1, 1));
    cmp_bit(clk_irq_req, 1'b1);
    prio(3'h6, 1'b0);
    prio(3'h5, 1'b1);
    pulse(1);
    cmp_bit(clk_irq_req, 1'b0);
    wr(LCB_OFF_BCR, bcr(0, 0, 0, 0, 0, 0));
    wr(LCB_OFF_CLK, 32'h40);
    for (int s = 1; s < 4; s++) begin
      wr(LCB_OFF_BCR, bcr(0, 0, 0, s[1:0], 0, 0));
      repeat (2) begin
        wait_lvl(0, 1'b1, 80, n);
        t0 = $time;
        pulse(1);
        wait_lvl(0, 1'b0, 4, n);
      end
      wait_lvl(0, 1'b1, 80, n);
      cmp_rd(32'(($time - t0) / 8), DV[s]);
    end
    wr(LCB_OFF_BCR, bcr(0, 0, 1, 0, 0, 0));
    pulse(2);
    seen(2, 4, h);
    cmp_bit(h, 1'b0);
    pulse(2);
    seen(2, 3, h);
    cmp_bit(h, 1'b1);
    wr(LCB_OFF_BCR, bcr(0, 0, 0, 0, 0, 0));
    pulse(2);
    seen(2, 3, h);
    cmp_bit(h, 1'b0);
    pulse(0);
    wr(LCB_OFF_BCR, bcr(0, 0, 1, 0, 0, 0));
    pulse(2);
    seen(2, 3, h);
    cmp_bit(h, 1'b0);
    pulse(3);
    pulse(2);
    seen(2, 3, h);
    cmp_bit(h, 1'b1);
    wr(LCB_OFF_BCR, bcr(0, 0, 0, 0, 0, 0));
    seen(1, 100, h);
    cmp_bit(h, 1'b0);
    // software uses only nonzero gap settings in normal running
    for (int s = 1; s < 8; s++) begin
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      @(posedge pclk);
      grant_delay <= rnd[3:0];
      wr(LCB_OFF_BCR, bcr(s[2:0], 0, 0, 0, 0, 0));
      for (int j = 0; j < 3; j++) begin
        wait_lvl(1, 1'b0, 40, n);
        n = 0;
        wait_lvl(1, 1'b1, (GAP << (s - 1)) + 20, n);
        if (j > 0) cmp_bit(n >= (GAP << (s - 1)) && n <= (GAP << (s - 1)) + 4, 1'b1);
        n = 0;
        wait_lvl(1, 1'b0, 40, n);
        cmp_bit(n >= int'(grant_delay), 1'b1);
      end
    end
    // tick, gap and halt events all stay sticky until cleared
    rd(LCB_OFF_IST, 32'h7, 1'b0);
    rd(LCB_OFF_IMSK, 32'h1, 1'b0);
    rd(LCB_OFF_BCR, 32'h8007, 1'b0);
    give_verdict();
  end
endmodule // lcb_ctrl_tb_top
